// ### logic/dpc_defines.svh
// Offsets, field positions, reset values and pin bit positions of the divider and PLL control bank.
// Assumes inclusion by bare name from files under logic/.
`ifndef DPC_DEFINES_SVH
`define DPC_DEFINES_SVH

// ============================================================
// Register offsets
`define DPC_ADDR_DIV_I        16'h0090
`define DPC_ADDR_DIV_A_TO_H   16'h0091
`define DPC_ADDR_LOOP_FILTER  16'h009a
`define DPC_ADDR_LOCK_COUNT   16'h009b
`define DPC_ADDR_VCO_FIRST    16'h009c
`define DPC_ADDR_VCO_SECOND   16'h009d
`define DPC_ADDR_BYPASS_REF   16'h009e
`define DPC_ADDR_PLL_RSVD     16'h009f

// ============================================================
// Field positions (least significant bit)
`define DPC_DIV_I_LSB         0
`define DPC_PUMP_LSB          5
`define DPC_SER_LSB           3
`define DPC_CAP_LSB           1
`define DPC_POLE2_LSB         0
`define DPC_LOCK_ACC_LSB      1
`define DPC_LOCK_MAN_LSB      0
`define DPC_MAN_VCO_LSB       5
`define DPC_CODE_LSB          0
`define DPC_BYP_LSB           4
`define DPC_REF_OE_LSB        2
`define DPC_PMODE_LSB         0

// ============================================================
// Reset values
`define DPC_RST_DIV_PD        8'h00
`define DPC_RST_DIV_I         1'b0
`define DPC_RST_PUMP          3'h4
`define DPC_RST_SER           2'h1
`define DPC_RST_CAP           2'h1
`define DPC_RST_POLE2         1'b1
`define DPC_RST_LOCK_ACC      1'b1
`define DPC_RST_LOCK_MAN      1'b0
`define DPC_RST_MAN_VCO       1'b1
`define DPC_RST_CODE1         5'h0b
`define DPC_RST_CODE2         5'h00
`define DPC_RST_BYP           1'b0
`define DPC_RST_REF_OE        1'b0
`define DPC_RST_PMODE         2'h3

// ============================================================
// Pin synchroniser bit positions and pin count
`define DPC_PIN_BYPASS        0
`define DPC_PIN_CLK_SEL       1
`define DPC_PIN_COUNT         2

`endif

// ### logic/dpc_pkg.sv
// Types shared by the divider and PLL control bank.
// Assumes nothing of its surroundings.
package dpc_pkg;

   // ============================================================
   // Reference pre-scaler modes
   typedef enum logic [1:0] {
      DPC_PRE_DIRECT = 2'b00,
      DPC_PRE_DIV2   = 2'b01,
      DPC_PRE_DIV4   = 2'b10,
      DPC_PRE_MUL2   = 2'b11
   } dpc_prescale_e;

   // ============================================================
   // Lock code selection
   typedef enum logic {
      DPC_LOCK_AUTO   = 1'b0,
      DPC_LOCK_MANUAL = 1'b1
   } dpc_lock_mode_e;

endpackage

// ### logic/dpc_sync_if.sv
// Carrier between the control bank and its pin synchroniser.
// Assumes the raw pins arrive from outside the core clock domain.
`timescale 1ns/100ps
`include "dpc_defines.svh"

interface dpc_sync_if;
   logic [`DPC_PIN_COUNT-1:0] raw;
   logic [`DPC_PIN_COUNT-1:0] synced;

   modport src (output raw, input synced);
   modport sync (input raw, output synced);
endinterface

// ### logic/dpc_pin_sync.sv
// Two-flop synchroniser for the asynchronous control pins.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/100ps
`include "dpc_defines.svh"

module dpc_pin_sync (
   input  wire logic core_clk_in,
   input  wire logic rst_n_in,
   dpc_sync_if.sync  pins
);

   // ============================================================
   // Per-pin double flop
   genvar g;
   generate
      for (g = 0; g < `DPC_PIN_COUNT; g++) begin : g_pin
         logic meta;
         logic stable;
         always_ff @(posedge core_clk_in) begin
            if (!rst_n_in) begin
               meta   <= 1'b0;
               stable <= 1'b0;
            end else begin
               meta   <= pins.raw[g];
               stable <= meta;
            end
         end
         assign pins.synced[g] = stable;
      end
   endgenerate

endmodule

// ### logic/dpc_control_regs.sv
// Divider power-down and PLL control register bank.
// Assumes the serial port logic drives the register port on core_clk_in.
//
// Operation
// [R1] Each output divider has its own power-down bit, zero runs it and one powers it down.
// [R2] Dividers A to H sit at bits 0 to 7 of 0x91 and divider I at bit 0 of 0x90.
// [R3] Software writes zero to reserved bits and never relies on their read value.
// [R4] A three-bit charge pump code sets current in 110uA steps, resetting to 100.
// [R5] A two-bit series resistor code picks 330, 640, 1200 or 1790 ohms, resetting to 01.
// [R6] A two-bit parallel capacitor code picks 40, 80, 140 or 200 pF, resetting to 01.
// [R7] The second-pole bit picks 497 or 1580 ohms post resistor, resetting to one.
// [R8] The lock count bit picks 1 ppm at zero or 16 ppm at one, resetting to one.
// [R9] The lock override bit picks automatic at zero or manual at one, resetting automatic.
// [R10] In manual mode the VCO select bit picks the first VCO at one, resetting to one.
// [R11] Two five-bit manual lock codes serve the two VCOs, resetting to 01011 and 00000.
// [R12] The bypass bit, like the bypass pin, drives Q0 to Q3 from the reference, reset zero.
// [R13] The reference output floats at enable zero and is driven from the input mux at one.
// [R14] A two-bit pre-scaler code passes, halves, quarters or doubles the reference, reset 11.
// [R15] Each register is eight bits, reads back its fields, and acts on the storing write.
`timescale 1ns/100ps
`include "dpc_defines.svh"

module dpc_control_regs
   import dpc_pkg::*;
(
   input  wire logic          core_clk_in,
   input  wire logic          rst_n_in,
   input  wire logic [15:0]   reg_addr_in,
   input  wire logic [7:0]    reg_wdata_in,
   input  wire logic          reg_wr_in,
   input  wire logic          reg_rd_in,
   input  wire logic          bypass_pin_in,
   input  wire logic          clk_sel_pin_in,
   input  wire logic          auto_vco_first_in,
   input  wire logic [4:0]    auto_lock_code_in,
   output logic [7:0]         reg_rdata_out,
   output logic               reg_rd_valid_out,
   output logic [8:0]         divider_power_down_out,
   output logic [2:0]         charge_pump_current_out,
   output logic [1:0]         series_resistor_select_out,
   output logic [1:0]         parallel_capacitor_select_out,
   output logic               second_pole_select_out,
   output logic               lock_count_accuracy_out,
   output dpc_lock_mode_e     lock_manual_override_out,
   output logic               vco_first_select_out,
   output logic [4:0]         lock_code_out,
   output logic               synth_loop_bypass_out,
   output logic               ref_out_oe_out,
   output logic               ref_mux_clk_sel_out,
   output dpc_prescale_e      prescale_mode_out
);

   // ============================================================
   // Stored fields
   logic [7:0]    div_pd_a_h;
   logic          div_pd_i;
   logic [2:0]    pump_cur;
   logic [1:0]    ser_sel;
   logic [1:0]    cap_sel;
   logic          pole2;
   logic          lock_acc;
   dpc_lock_mode_e lock_mode;
   logic          man_vco;
   logic [4:0]    code_first;
   logic [4:0]    code_second;
   logic          byp_bit;
   logic          ref_oe;
   dpc_prescale_e pmode;

   // ============================================================
   // Next values
   logic [7:0]    next_div_pd_a_h;
   logic          next_div_pd_i;
   logic          next_lock_manual;
   logic          next_man_vco;
   logic [4:0]    next_code_first;
   logic [4:0]    next_code_second;
   logic          next_byp_bit;
   logic          next_ref_oe;

   // ============================================================
   // Write decode and read word
   logic          wr_div_i;
   logic          wr_div_a_h;
   logic          wr_loop;
   logic          wr_lock;
   logic          wr_vco1;
   logic          wr_vco2;
   logic          wr_byp;
   logic [7:0]    read_word;

   // ============================================================
   // Pin synchroniser
   dpc_sync_if    pin_bus ();

   assign pin_bus.raw[`DPC_PIN_BYPASS]  = bypass_pin_in;
   assign pin_bus.raw[`DPC_PIN_CLK_SEL] = clk_sel_pin_in;

   dpc_pin_sync u_pin_sync (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_in),
      .pins        (pin_bus.sync)
   );

   // Writes to unmapped or reserved-only offsets fall through silently
   assign wr_div_i   = reg_wr_in && (reg_addr_in == `DPC_ADDR_DIV_I);
   assign wr_div_a_h = reg_wr_in && (reg_addr_in == `DPC_ADDR_DIV_A_TO_H);
   assign wr_loop    = reg_wr_in && (reg_addr_in == `DPC_ADDR_LOOP_FILTER);
   assign wr_lock    = reg_wr_in && (reg_addr_in == `DPC_ADDR_LOCK_COUNT);
   assign wr_vco1    = reg_wr_in && (reg_addr_in == `DPC_ADDR_VCO_FIRST);
   assign wr_vco2    = reg_wr_in && (reg_addr_in == `DPC_ADDR_VCO_SECOND);
   assign wr_byp     = reg_wr_in && (reg_addr_in == `DPC_ADDR_BYPASS_REF);

   // ============================================================
   // Next-value selection
   // Derived outputs see the incoming write, so a setting acts on its own edge
   always_comb begin
      next_div_pd_a_h = wr_div_a_h ? reg_wdata_in : div_pd_a_h; // [R2]
      next_div_pd_i   = wr_div_i ? reg_wdata_in[`DPC_DIV_I_LSB] : div_pd_i; // [R2]
   end

   always_comb begin
      next_lock_manual = wr_lock ? reg_wdata_in[`DPC_LOCK_MAN_LSB] : lock_mode; // [R9]
      next_man_vco     = wr_vco1 ? reg_wdata_in[`DPC_MAN_VCO_LSB] : man_vco; // [R10]
      next_code_first  = wr_vco1 ? reg_wdata_in[`DPC_CODE_LSB +: 5] : code_first; // [R11]
      next_code_second = wr_vco2 ? reg_wdata_in[`DPC_CODE_LSB +: 5] : code_second; // [R11]
   end

   always_comb begin
      next_byp_bit = wr_byp ? reg_wdata_in[`DPC_BYP_LSB] : byp_bit; // [R12]
      next_ref_oe  = wr_byp ? reg_wdata_in[`DPC_REF_OE_LSB] : ref_oe; // [R13]
   end

   // ============================================================
   // Divider power-down
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         div_pd_a_h <= `DPC_RST_DIV_PD;
         div_pd_i   <= `DPC_RST_DIV_I;
      end else begin
         div_pd_a_h <= next_div_pd_a_h; // [R1]
         div_pd_i   <= next_div_pd_i; // [R1]
      end
   end

   // ============================================================
   // Loop filter and charge pump
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         pump_cur <= `DPC_RST_PUMP;
         ser_sel  <= `DPC_RST_SER;
         cap_sel  <= `DPC_RST_CAP;
         pole2    <= `DPC_RST_POLE2;
      end else if (wr_loop) begin
         pump_cur <= reg_wdata_in[`DPC_PUMP_LSB +: 3]; // [R4]
         ser_sel  <= reg_wdata_in[`DPC_SER_LSB +: 2]; // [R5]
         cap_sel  <= reg_wdata_in[`DPC_CAP_LSB +: 2]; // [R6]
         pole2    <= reg_wdata_in[`DPC_POLE2_LSB]; // [R7]
      end
   end

   // ============================================================
   // Lock detection
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         lock_acc  <= `DPC_RST_LOCK_ACC;
         lock_mode <= dpc_lock_mode_e'(`DPC_RST_LOCK_MAN);
      end else begin
         if (wr_lock) begin
            lock_acc <= reg_wdata_in[`DPC_LOCK_ACC_LSB]; // [R8]
         end
         lock_mode <= dpc_lock_mode_e'(next_lock_manual); // [R9]
      end
   end

   // ============================================================
   // Manual VCO and lock codes
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         man_vco     <= `DPC_RST_MAN_VCO;
         code_first  <= `DPC_RST_CODE1;
         code_second <= `DPC_RST_CODE2;
      end else begin
         man_vco     <= next_man_vco; // [R10]
         code_first  <= next_code_first; // [R11]
         code_second <= next_code_second; // [R11]
      end
   end

   // ============================================================
   // Bypass, reference output and pre-scaler
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         byp_bit <= `DPC_RST_BYP;
         ref_oe  <= `DPC_RST_REF_OE;
         pmode   <= dpc_prescale_e'(`DPC_RST_PMODE);
      end else begin
         byp_bit <= next_byp_bit; // [R12]
         ref_oe  <= next_ref_oe; // [R13]
         if (wr_byp) begin
            pmode <= dpc_prescale_e'(reg_wdata_in[`DPC_PMODE_LSB +: 2]); // [R14]
         end
      end
   end

   // ============================================================
   // Effective lock code
   // Auto inputs come from the lock engine on this clock, so no sync
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         vco_first_select_out <= `DPC_RST_MAN_VCO;
         lock_code_out        <= `DPC_RST_CODE1;
      end else if (next_lock_manual) begin
         vco_first_select_out <= next_man_vco; // [R10]
         lock_code_out        <= next_man_vco ? next_code_first : next_code_second; // [R11]
      end else begin
         vco_first_select_out <= auto_vco_first_in; // [R9]
         lock_code_out        <= auto_lock_code_in; // [R9]
      end
   end

   // ============================================================
   // Effective bypass
   // Pin and register are ORed, so either one alone forces bypass
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         synth_loop_bypass_out <= `DPC_RST_BYP;
      end else begin
         synth_loop_bypass_out <= next_byp_bit | pin_bus.synced[`DPC_PIN_BYPASS]; // [R12]
      end
   end

   // ============================================================
   // Reference output drive
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         ref_out_oe_out      <= `DPC_RST_REF_OE;
         ref_mux_clk_sel_out <= 1'b0;
      end else begin
         ref_out_oe_out      <= next_ref_oe; // [R13]
         ref_mux_clk_sel_out <= pin_bus.synced[`DPC_PIN_CLK_SEL]; // [R13]
      end
   end

   // ============================================================
   // Field outputs
   assign divider_power_down_out        = {div_pd_i, div_pd_a_h}; // [R1]
   assign charge_pump_current_out       = pump_cur;
   assign series_resistor_select_out    = ser_sel;
   assign parallel_capacitor_select_out = cap_sel;
   assign second_pole_select_out        = pole2;
   assign lock_count_accuracy_out       = lock_acc;
   assign lock_manual_override_out      = lock_mode;
   assign prescale_mode_out             = pmode;

   // ============================================================
   // Readback
   // Reserved bits are not stored and read as zero
   always_comb begin
      read_word = 8'h00;
      case (reg_addr_in)
         `DPC_ADDR_DIV_I: begin
            read_word[`DPC_DIV_I_LSB] = div_pd_i; // [R15]
         end
         `DPC_ADDR_DIV_A_TO_H: begin
            read_word = div_pd_a_h; // [R15]
         end
         `DPC_ADDR_LOOP_FILTER: begin
            read_word[`DPC_PUMP_LSB +: 3] = pump_cur; // [R15]
            read_word[`DPC_SER_LSB +: 2]  = ser_sel;
            read_word[`DPC_CAP_LSB +: 2]  = cap_sel;
            read_word[`DPC_POLE2_LSB]     = pole2;
         end
         `DPC_ADDR_LOCK_COUNT: begin
            read_word[`DPC_LOCK_ACC_LSB] = lock_acc; // [R15]
            read_word[`DPC_LOCK_MAN_LSB] = lock_mode;
         end
         `DPC_ADDR_VCO_FIRST: begin
            read_word[`DPC_MAN_VCO_LSB]   = man_vco; // [R15]
            read_word[`DPC_CODE_LSB +: 5] = code_first;
         end
         `DPC_ADDR_VCO_SECOND: begin
            read_word[`DPC_CODE_LSB +: 5] = code_second; // [R15]
         end
         `DPC_ADDR_BYPASS_REF: begin
            read_word[`DPC_BYP_LSB]        = byp_bit; // [R15]
            read_word[`DPC_REF_OE_LSB]     = ref_oe;
            read_word[`DPC_PMODE_LSB +: 2] = pmode;
         end
         default: begin
            read_word = 8'h00;
         end
      endcase
   end

   // ============================================================
   // Read response
   // One cycle late so the serial port sees a clean flop output
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         reg_rdata_out    <= 8'h00;
         reg_rd_valid_out <= 1'b0;
      end else begin
         reg_rd_valid_out <= reg_rd_in;
         if (reg_rd_in) begin
            reg_rdata_out <= read_word;
         end
      end
   end

endmodule

// ### dv/dpc_control_regs_chk.sv
// Concurrent checks on the divider and PLL control bank ports.
// Assumes binding to dpc_control_regs, one core clock, synchronous reset.
`timescale 1ns/100ps

module dpc_control_regs_chk
   import dpc_pkg::*;
(
   input wire logic           core_clk_in,
   input wire logic           rst_n_in,
   input wire logic [15:0]    reg_addr_in,
   input wire logic [7:0]     reg_wdata_in,
   input wire logic           reg_wr_in,
   input wire logic           reg_rd_in,
   input wire logic           auto_vco_first_in,
   input wire logic [4:0]     auto_lock_code_in,
   input wire logic [7:0]     reg_rdata_out,
   input wire logic           reg_rd_valid_out,
   input wire logic [8:0]     divider_power_down_out,
   input wire logic [2:0]     charge_pump_current_out,
   input wire logic [1:0]     series_resistor_select_out,
   input wire logic [1:0]     parallel_capacitor_select_out,
   input wire logic           second_pole_select_out,
   input wire dpc_lock_mode_e lock_manual_override_out,
   input wire logic           vco_first_select_out,
   input wire logic [4:0]     lock_code_out,
   input wire logic           synth_loop_bypass_out,
   input wire logic           ref_out_oe_out,
   input wire dpc_prescale_e  prescale_mode_out
);
   // ============================================================
   // Write decode
   wire logic       wr_lf = reg_wr_in && reg_addr_in == 16'h009a;
   wire logic       wr_br = reg_wr_in && reg_addr_in == 16'h009e;
   wire logic [7:0] lf    = {charge_pump_current_out, series_resistor_select_out,
                             parallel_capacitor_select_out, second_pole_select_out};

   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);

   // ============================================================
   // Properties
   a_rd_valid_next: assert property (reg_rd_in |=> reg_rd_valid_out)
      else $error("read strobe without valid one cycle later");
   a_valid_has_cause: assert property (reg_rd_valid_out |-> $past(reg_rd_in))
      else $error("read valid without a read strobe");
   a_div_ah_write: assert property (reg_wr_in && reg_addr_in == 16'h0091
      |=> divider_power_down_out[7:0] == $past(reg_wdata_in))
      else $error("dividers A to H not stored from write");
   a_div_i_write: assert property (reg_wr_in && reg_addr_in == 16'h0090
      |=> divider_power_down_out[8] == $past(reg_wdata_in[0]))
      else $error("divider I not stored from write");
   a_loop_filter_write: assert property (wr_lf |=> lf == $past(reg_wdata_in))
      else $error("loop filter fields not stored from write");
   a_loop_filter_hold: assert property (!wr_lf |=> $stable(lf))
      else $error("loop filter fields moved without write");
   a_prescale_write: assert property (wr_br |=> prescale_mode_out == $past(reg_wdata_in[1:0])
      && ref_out_oe_out == $past(reg_wdata_in[2]))
      else $error("pre-scaler or ref enable not stored");
   a_bypass_write: assert property (wr_br && reg_wdata_in[4] |=> synth_loop_bypass_out)
      else $error("bypass bit set but bypass low");
   a_auto_follow: assert property (lock_manual_override_out == DPC_LOCK_AUTO && !reg_wr_in
      |=> lock_code_out == $past(auto_lock_code_in)
      && vco_first_select_out == $past(auto_vco_first_in))
      else $error("automatic lock values not followed");
   a_manual_steady: assert property (lock_manual_override_out == DPC_LOCK_MANUAL && !reg_wr_in
      |=> $stable(lock_code_out) && $stable(vco_first_select_out))
      else $error("manual lock values moved without write");
   a_reserved_read: assert property (reg_rd_in && reg_addr_in == 16'h009f
      |=> reg_rdata_out == 8'h00)
      else $error("reserved register read not zero");
endmodule

bind dpc_control_regs dpc_control_regs_chk chk (.core_clk_in, .rst_n_in, .reg_addr_in,
   .reg_wdata_in, .reg_wr_in, .reg_rd_in, .auto_vco_first_in, .auto_lock_code_in,
   .reg_rdata_out, .reg_rd_valid_out, .divider_power_down_out, .charge_pump_current_out,
   .series_resistor_select_out, .parallel_capacitor_select_out, .second_pole_select_out,
   .lock_manual_override_out, .vco_first_select_out, .lock_code_out,
   .synth_loop_bypass_out, .ref_out_oe_out, .prescale_mode_out);

// ### dv/dpc_control_regs_bench.sv
// Self-checking bench of the divider and PLL control bank.
// Assumes the design files under logic/ and the bound checker.
`timescale 1ns/100ps
`include "dpc_defines.svh"

module dpc_control_regs_bench
   import dpc_pkg::*;
();
   // ============================================================
   // Stimulus and observed ports
   logic core_clk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
   logic bypass_pin_in = 1'b0, clk_sel_pin_in = 1'b0, auto_vco_first_in = 1'b0;
   logic [15:0] reg_addr_in = 16'h0000;
   logic [7:0] reg_wdata_in = 8'h00, q;
   logic [4:0] auto_lock_code_in = 5'h07;
   logic [7:0] reg_rdata_out;
   logic reg_rd_valid_out, second_pole_select_out, lock_count_accuracy_out;
   logic vco_first_select_out, synth_loop_bypass_out, ref_out_oe_out, ref_mux_clk_sel_out;
   logic [8:0] divider_power_down_out;
   logic [2:0] charge_pump_current_out;
   logic [1:0] series_resistor_select_out, parallel_capacitor_select_out;
   logic [4:0] lock_code_out;
   dpc_lock_mode_e lock_manual_override_out;
   dpc_prescale_e prescale_mode_out;
   int mismatches = 0, tests_run = 0, cycles = 0;
   // Address, write data, expected read; reserved bits written as zero
   logic [31:0] rows [9] = '{{`DPC_ADDR_DIV_I, 8'h01, 8'h01},
      {`DPC_ADDR_DIV_A_TO_H, 8'ha5, 8'ha5}, {`DPC_ADDR_LOOP_FILTER, 8'h5a, 8'h5a},
      {`DPC_ADDR_LOCK_COUNT, 8'h02, 8'h02}, {`DPC_ADDR_VCO_FIRST, 8'h15, 8'h15},
      {`DPC_ADDR_VCO_SECOND, 8'h0e, 8'h0e}, {`DPC_ADDR_BYPASS_REF, 8'h12, 8'h12},
      {`DPC_ADDR_PLL_RSVD, 8'h00, 8'h00}, {16'h0080, 8'hff, 8'h00}};

   dpc_control_regs uut (.core_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
      .reg_rd_in, .bypass_pin_in, .clk_sel_pin_in, .auto_vco_first_in, .auto_lock_code_in,
      .reg_rdata_out, .reg_rd_valid_out, .divider_power_down_out, .charge_pump_current_out,
      .series_resistor_select_out, .parallel_capacitor_select_out, .second_pole_select_out,
      .lock_count_accuracy_out, .lock_manual_override_out, .vco_first_select_out,
      .lock_code_out, .synth_loop_bypass_out, .ref_out_oe_out, .ref_mux_clk_sel_out,
      .prescale_mode_out);

   always #5 core_clk_in = ~core_clk_in;

   // ============================================================
   // Tasks
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
      #1;
   endtask

   // Strobe taken at the second edge, answer lands on that same edge
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge core_clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge core_clk_in);
      reg_rd_in <= 1'b0;
      #1;
      chk("rd_valid", reg_rd_valid_out, 1'b1);
      d = reg_rdata_out;
   endtask

   task automatic check_reset();
      chk("rst_div", divider_power_down_out, 9'h000);
      chk("rst_lf", {charge_pump_current_out, series_resistor_select_out,
         parallel_capacitor_select_out, second_pole_select_out}, 8'h8b);
      chk("rst_lock_acc", lock_count_accuracy_out, 1'b1);
      chk("rst_mode", lock_manual_override_out, DPC_LOCK_AUTO);
      chk("rst_vco", vco_first_select_out, 1'b1);
      chk("rst_code", lock_code_out, 5'h0b);
      chk("rst_byp", synth_loop_bypass_out, 1'b0);
      chk("rst_oe", ref_out_oe_out, 1'b0);
      chk("rst_pmode", prescale_mode_out, DPC_PRE_MUL2);
   endtask

   task automatic conclude();
      if (mismatches == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Whole run is about 120 cycles
   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         conclude();
      end
   end

   // ============================================================
   // Sequence
   initial begin
      repeat (5) @(posedge core_clk_in);
      #1;
      check_reset();
      @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      #1;
      chk("auto_code", lock_code_out, 5'h07);
      chk("auto_vco", vco_first_select_out, 1'b0);
      foreach (rows[i]) begin
         wr(rows[i][31:16], rows[i][15:8]);
         rd(rows[i][31:16], q);
         chk("rdata", q, rows[i][7:0]);
      end
      chk("div_pd", divider_power_down_out, 9'h1a5);
      for (int k = 0; k < 8; k++) begin
         wr(`DPC_ADDR_LOOP_FILTER, {k[2:0], k[1:0], k[1:0], k[0]});
         chk("pump", charge_pump_current_out, k[2:0]);
         chk("series", series_resistor_select_out, k[1:0]);
         chk("cap", parallel_capacitor_select_out, k[1:0]);
         chk("pole2", second_pole_select_out, k[0]);
         wr(`DPC_ADDR_BYPASS_REF, {3'h0, k[0], 1'b0, k[2], k[1:0]});
         chk("pmode", prescale_mode_out, k[1:0]);
         chk("ref_oe", ref_out_oe_out, k[2]);
         chk("byp", synth_loop_bypass_out, k[0]);
         wr(`DPC_ADDR_LOCK_COUNT, {6'h00, k[0], 1'b0});
         chk("lock_acc", lock_count_accuracy_out, k[0]);
      end
      // Manual mode must ignore the lock engine
      auto_lock_code_in <= 5'h1c;
      auto_vco_first_in <= 1'b1;
      wr(`DPC_ADDR_LOCK_COUNT, 8'h01);
      chk("man_code2", lock_code_out, 5'h0e);
      chk("man_vco2", vco_first_select_out, 1'b0);
      wr(`DPC_ADDR_VCO_FIRST, 8'h35);
      chk("man_code1", lock_code_out, 5'h15);
      chk("man_vco1", vco_first_select_out, 1'b1);
      // Write and read together return the old byte
      @(posedge core_clk_in);
      reg_addr_in <= `DPC_ADDR_VCO_SECOND;
      reg_wdata_in <= 8'h1f;
      reg_wr_in <= 1'b1;
      reg_rd_in <= 1'b1;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
      reg_rd_in <= 1'b0;
      @(posedge core_clk_in);
      #1;
      chk("old_rdata", reg_rdata_out, 8'h0e);
      rd(`DPC_ADDR_VCO_SECOND, q);
      chk("new_rdata", q, 8'h1f);
      // Pins go through two sync flops and an output flop
      wr(`DPC_ADDR_BYPASS_REF, 8'h04);
      @(posedge core_clk_in);
      bypass_pin_in <= 1'b1;
      clk_sel_pin_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      #1;
      chk("pin_byp", synth_loop_bypass_out, 1'b1);
      chk("pin_sel", ref_mux_clk_sel_out, 1'b1);
      @(posedge core_clk_in);
      rst_n_in <= 1'b0;
      repeat (5) @(posedge core_clk_in);
      #1;
      check_reset();
      @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      rd(`DPC_ADDR_VCO_FIRST, q);
      chk("rst_rd9c", q, 8'h2b);
      rd(`DPC_ADDR_BYPASS_REF, q);
      chk("rst_rd9e", q, 8'h03);
      conclude();
   end
endmodule
